// ==== core/dmcp_pkg.sv ====
package dmcp_pkg;
  // Clock and link timing
  localparam int CLK_NS = 25;
  localparam int LINK_QTR_NS = 100;
  localparam int LINK_QTR_CYC = (LINK_QTR_NS + CLK_NS - 1) / CLK_NS;
  // Addressing
  localparam logic [5:0] I2C_PREFIX = 6'h08;
  localparam logic [7:0] SPI_ADDR_BYTE = 8'h20;
  localparam int AUTO_INC_BIT = 7;
  localparam int IDX_W = 3;
  localparam int NREG = 5;
  localparam int BYTE_LAST_BIT = 7;
  localparam int ACK_SLOT = 8;
  // Register defaults, index 4 down to 0
  localparam logic [NREG-1:0][7:0] REG_RST = {8'h00, 8'h00, 8'h00, 8'h83, 8'h00};
  localparam logic [7:0] PTR_RST = 8'h00;
  // Host command port map
  localparam logic [2:0] HA_CMD = 3'h0;
  localparam logic [2:0] HA_PTR = 3'h1;
  localparam logic [2:0] HA_WDATA = 3'h2;
  localparam logic [2:0] HA_STATUS = 3'h3;
  localparam logic [2:0] HA_RDATA = 3'h4;
  localparam logic [1:0] OP_I2C_WR = 2'h0;
  localparam logic [1:0] OP_I2C_RD = 2'h1;
  localparam logic [1:0] OP_SPI_WR = 2'h2;
  localparam logic [1:0] OP_I2C_PTR = 2'h3;
endpackage : dmcp_pkg

// ==== core/dmcp_link_if.sv ====
`timescale 1ns/1ps
interface dmcp_link_if;
  logic control_clock;
  logic address_select_pin;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic control_data_in;
  // Wired-and with pull-up; an undriven line reads high
  assign control_data_in = (~sda_host_oe | sda_host_out) & (~sda_dev_oe | sda_dev_out);
  modport dev (
    input control_clock, address_select_pin, control_data_in,
    output sda_dev_out, sda_dev_oe
  );
  modport host (
    output control_clock, address_select_pin, sda_host_out, sda_host_oe,
    input control_data_in
  );
endinterface : dmcp_link_if

// ==== core/dmcp_dev.sv ====
`timescale 1ns/1ps
// What this block does
// - Port runs independent of audio timing
// - Host keeps master clock during bus transfers
// - Auto-increment clear keeps pointer unchanged
// - Auto-increment set advances pointer per byte
// - Pointer: flag bit7, reserved, index bits2-0
// - Two-wire address is prefix plus select pin
// - Host fixes select pin before power-up
// - First select-pin falling edge selects serial-peripheral
// - Write: address, ack, pointer loaded, ack
// - Further bytes acked and stored, then stop
// - Other register without increment needs restart
// - Read: address with read bit, ack, data
// - Read uses last written pointer or default
// - Increment read streams registers; host acks each
// - Serial-peripheral samples data on rising clock
// - Frame: select low, address, pointer, data
// - Host raises select to end each frame
// - Registers readable two-wire, write-only serial-peripheral
// - Reset input low restores all defaults
module dmcp_dev
  import dmcp_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic ctl_rst_n_in,
  // Link
  dmcp_link_if.dev link,
  // User side
  output logic [NREG*8-1:0] regs_out,
  output logic [IDX_W-1:0] ptr_idx_out,
  output logic ptr_auto_out,
  output logic spi_mode_out
);

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} dmcp_dst_t;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} dmcp_ph_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] cs_s;
    logic scl_f;
    logic sda_f;
    logic cs_f;
    logic spi_mode;
    dmcp_dst_t st;
    dmcp_ph_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic acked;
    logic auto_inc;
    logic [IDX_W-1:0] idx;
    logic sda_oe;
    logic [NREG-1:0][7:0] regs;
  } dmcp_dev_st_t;

  localparam dmcp_dev_st_t DEV_RST = '{
    scl_s: 3'h7, sda_s: 3'h7, cs_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, cs_f: 1'b1,
    spi_mode: 1'b0, st: ST_IDLE, ph: PH_ADDR, cnt: 4'h0, sh: 8'h00, rw: 1'b0,
    acked: 1'b0, auto_inc: PTR_RST[AUTO_INC_BIT], idx: PTR_RST[IDX_W-1:0],
    sda_oe: 1'b0, regs: REG_RST
  };

  dmcp_dev_st_t q;
  dmcp_dev_st_t nxt;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic cs_fall;
  logic byte_done;
  logic [7:0] byte_val;

  // Index check shared by read and write paths
  function automatic logic reg_ok(input logic [IDX_W-1:0] i);
    reg_ok = (int'(i) < NREG);
  endfunction : reg_ok

  function automatic logic [7:0] rd_reg(input logic [NREG-1:0][7:0] r,
                                        input logic [IDX_W-1:0] i);
    rd_reg = 8'h00;
    for (int k = 0; k < NREG; k++) begin
      if (reg_ok(i) && int'(i) == k) begin
        rd_reg = r[k];
      end
    end
  endfunction : rd_reg

  // Next-state logic for the whole port
  always_comb begin
    nxt = q;
    // Three-stage sync; a level counts once stages two and three agree
    nxt.scl_s = {q.scl_s[1:0], link.control_clock};
    nxt.sda_s = {q.sda_s[1:0], link.control_data_in};
    nxt.cs_s = {q.cs_s[1:0], link.address_select_pin};
    if (q.scl_s[1] == q.scl_s[2]) begin
      nxt.scl_f = q.scl_s[2];
    end
    if (q.sda_s[1] == q.sda_s[2]) begin
      nxt.sda_f = q.sda_s[2];
    end
    if (q.cs_s[1] == q.cs_s[2]) begin
      nxt.cs_f = q.cs_s[2];
    end
    scl_rise = nxt.scl_f & ~q.scl_f;
    scl_fall = ~nxt.scl_f & q.scl_f;
    sda_rise = nxt.sda_f & ~q.sda_f;
    sda_fall = ~nxt.sda_f & q.sda_f;
    cs_fall = ~nxt.cs_f & q.cs_f;
    byte_done = 1'b0;
    byte_val = q.sh;
    // Mode latch never clears; only reset brings back two-wire mode
    if (cs_fall) begin
      nxt.spi_mode = 1'b1;
    end
    if (q.spi_mode || cs_fall) begin
      nxt.sda_oe = 1'b0;
      if (nxt.cs_f) begin
        nxt.st = ST_IDLE;
      end else if (cs_fall) begin
        nxt.st = ST_RX;
        nxt.ph = PH_ADDR;
        nxt.cnt = 4'h0;
        nxt.rw = 1'b0;
      end else if (scl_rise && q.st == ST_RX) begin
        nxt.sh = {q.sh[6:0], q.sda_f};
        nxt.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(BYTE_LAST_BIT)) begin
          byte_done = 1'b1;
          byte_val = nxt.sh;
          nxt.cnt = 4'h0;
        end
      end
    end else if (scl_fall == 1'b0 && sda_fall && q.scl_f) begin
      // Start or repeated start
      nxt.st = ST_RX;
      nxt.ph = PH_ADDR;
      nxt.cnt = 4'h0;
      nxt.sda_oe = 1'b0;
    end else if (scl_fall == 1'b0 && sda_rise && q.scl_f) begin
      nxt.st = ST_IDLE;
      nxt.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          nxt.sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            nxt.sh = {q.sh[6:0], q.sda_f};
            nxt.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == 4'(ACK_SLOT)) begin
            byte_done = 1'b1;
            nxt.cnt = 4'h0;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt.sda_oe = 1'b0;
            nxt.st = ST_RX;
            if (q.rw) begin
              nxt.sh = rd_reg(q.regs, q.idx);
              nxt.sda_oe = ~nxt.sh[7];
              nxt.st = ST_TX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (q.cnt == 4'(BYTE_LAST_BIT)) begin
              nxt.sda_oe = 1'b0;
              nxt.st = ST_RACK;
              nxt.cnt = 4'h0;
              if (q.auto_inc) begin
                nxt.idx = q.idx + 1'b1;
              end
            end else begin
              nxt.sh = {q.sh[6:0], 1'b0};
              nxt.sda_oe = ~nxt.sh[7];
              nxt.cnt = q.cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nxt.acked = ~q.sda_f;
          end else if (scl_fall) begin
            // A missing ack ends the stream; wait for stop
            nxt.st = ST_IDLE;
            if (q.acked) begin
              nxt.sh = rd_reg(q.regs, q.idx);
              nxt.sda_oe = ~nxt.sh[7];
              nxt.st = ST_TX;
            end
          end
        end
        default: begin
          nxt.st = ST_IDLE;
        end
      endcase
    end
    // Byte interpretation common to both modes
    if (byte_done) begin
      if (!q.spi_mode && !cs_fall) begin
        nxt.st = ST_ACK;
        nxt.sda_oe = 1'b1;
      end
      unique case (q.ph)
        PH_ADDR: begin
          if (q.spi_mode ? (byte_val == SPI_ADDR_BYTE)
                         : (byte_val[7:1] == {I2C_PREFIX, q.cs_f})) begin
            nxt.rw = q.spi_mode ? 1'b0 : byte_val[0];
            nxt.ph = nxt.rw ? PH_DATA : PH_PTR;
          end else begin
            nxt.st = ST_IDLE;
            nxt.sda_oe = 1'b0;
          end
        end
        PH_PTR: begin
          // Reserved pointer bits are dropped
          nxt.auto_inc = byte_val[AUTO_INC_BIT];
          nxt.idx = byte_val[IDX_W-1:0];
          nxt.ph = PH_DATA;
        end
        PH_DATA: begin
          for (int k = 0; k < NREG; k++) begin
            if (reg_ok(q.idx) && int'(q.idx) == k) begin
              nxt.regs[k] = byte_val;
            end
          end
          if (q.auto_inc) begin
            nxt.idx = q.idx + 1'b1;
          end else begin
            nxt.idx = q.idx;
          end
        end
        default: begin
          nxt.ph = PH_ADDR;
        end
      endcase
    end
  end

  // Single state register; the reset pin clears port and settings
  always_ff @(posedge mclk_in) begin
    if (srst_in || !ctl_rst_n_in) begin
      q <= DEV_RST;
    end else if (ce_in) begin
      q <= nxt;
    end
  end

  assign regs_out = q.regs;
  assign ptr_idx_out = q.idx;
  assign ptr_auto_out = q.auto_inc;
  assign spi_mode_out = q.spi_mode;
  assign link.sda_dev_oe = q.sda_oe;
  assign link.sda_dev_out = 1'b0; // Open drain: only ever pulls low
endmodule : dmcp_dev

// ==== core/dmcp_host.sv ====
`timescale 1ns/1ps
module dmcp_host
  import dmcp_pkg::*;
#(
  parameter logic ASEL_LEVEL = 1'b1
)
(
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Command port
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic busy_out,
  // Link
  dmcp_link_if.host link
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} dmcp_hst_t;

  typedef struct packed {
    logic [2:0] sda_s;
    logic sda_f;
    dmcp_hst_t st;
    logic [2:0] tcnt;
    logic [1:0] qt;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [1:0] nbytes;
    logic spi;
    logic rd;
    logic nack;
    logic [7:0] ptr;
    logic [7:0] wdat;
    logic [7:0] rxd;
    logic [7:0] rdata;
    logic scl;
    logic cs;
    logic sda_o;
    logic sda_oe;
    logic busy;
  } dmcp_host_st_t;

  localparam dmcp_host_st_t HOST_RST = '{
    sda_s: 3'h7, sda_f: 1'b1, st: H_IDLE, tcnt: 3'h0, qt: 2'h0, bitn: 4'h0,
    byten: 2'h0, nbytes: 2'h0, spi: 1'b0, rd: 1'b0, nack: 1'b0, ptr: PTR_RST,
    wdat: 8'h00, rxd: 8'h00, rdata: 8'h00, scl: 1'b1, cs: ASEL_LEVEL,
    sda_o: 1'b1, sda_oe: 1'b0, busy: 1'b0
  };

  dmcp_host_st_t q;
  dmcp_host_st_t nxt;
  logic tick;
  logic rx_byte;
  logic [7:0] cur;
  logic bitv;

  always_comb begin
    nxt = q;
    nxt.sda_s = {q.sda_s[1:0], link.control_data_in};
    if (q.sda_s[1] == q.sda_s[2]) begin
      nxt.sda_f = q.sda_s[2];
    end
    // Quarter-bit divider; link clock period is four quarters
    tick = (q.tcnt == 3'(LINK_QTR_CYC - 1));
    nxt.tcnt = tick ? 3'h0 : q.tcnt + 3'h1;
    rx_byte = q.rd && q.byten == 2'h1;
    unique case (q.byten)
      2'h0: cur = q.spi ? SPI_ADDR_BYTE : {I2C_PREFIX, ASEL_LEVEL, q.rd};
      2'h1: cur = q.ptr;
      default: cur = q.wdat;
    endcase
    // Ack slot and received bits leave the line released
    bitv = (q.bitn < 4'(ACK_SLOT) && !rx_byte) ? cur[3'(BYTE_LAST_BIT) - q.bitn[2:0]] : 1'b1;
    // Register reads answer one cycle later
    nxt.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        HA_PTR: nxt.rdata = q.ptr;
        HA_WDATA: nxt.rdata = q.wdat;
        HA_STATUS: nxt.rdata = {5'h00, q.spi, q.nack, q.st != H_IDLE};
        HA_RDATA: nxt.rdata = q.rxd;
        default: nxt.rdata = 8'h00;
      endcase
    end
    if (wr_in && addr_in == HA_PTR) begin
      nxt.ptr = wdata_in;
    end
    if (wr_in && addr_in == HA_WDATA) begin
      nxt.wdat = wdata_in;
    end
    // Commands while busy are dropped
    if (wr_in && addr_in == HA_CMD && q.st == H_IDLE) begin
      nxt.st = H_START;
      nxt.tcnt = 3'h0;
      nxt.qt = 2'h0;
      nxt.byten = 2'h0;
      nxt.bitn = 4'h0;
      nxt.nack = 1'b0;
      nxt.spi = wdata_in[1:0] == OP_SPI_WR;
      nxt.rd = wdata_in[1:0] == OP_I2C_RD;
      nxt.nbytes = (wdata_in[1:0] == OP_I2C_WR || wdata_in[1:0] == OP_SPI_WR) ? 2'h3 : 2'h2;
    end else if (tick && q.st != H_IDLE) begin
      nxt.qt = q.qt + 2'h1;
      unique case (q.st)
        H_START: begin
          if (q.qt == 2'h0) begin
            if (q.spi) begin
              nxt.cs = 1'b0;
            end else begin
              nxt.sda_oe = 1'b1;
              nxt.sda_o = 1'b0;
            end
          end else if (q.qt == 2'h2) begin
            nxt.scl = 1'b0;
          end else if (q.qt == 2'h3) begin
            nxt.st = H_BITS;
          end
        end
        H_BITS: begin
          unique case (q.qt)
            2'h0: begin
              nxt.sda_o = q.spi ? bitv : 1'b0;
              nxt.sda_oe = q.spi ? 1'b1 : ~bitv;
            end
            2'h1: nxt.scl = 1'b1;
            2'h2: begin
              if (rx_byte && q.bitn < 4'(ACK_SLOT)) begin
                nxt.rxd = {q.rxd[6:0], q.sda_f};
              end else if (q.bitn == 4'(ACK_SLOT) && !rx_byte) begin
                nxt.nack = q.nack | q.sda_f;
              end
            end
            default: begin
              nxt.scl = 1'b0;
              nxt.bitn = q.bitn + 4'h1;
              if (q.bitn == (q.spi ? 4'(BYTE_LAST_BIT) : 4'(ACK_SLOT))) begin
                nxt.bitn = 4'h0;
                nxt.byten = q.byten + 2'h1;
                if (nxt.byten == q.nbytes || nxt.nack) begin
                  nxt.st = H_STOP;
                end
              end
            end
          endcase
        end
        default: begin
          if (q.qt == 2'h0) begin
            nxt.sda_oe = !q.spi;
            nxt.sda_o = 1'b0;
          end else if (q.qt == 2'h1) begin
            nxt.scl = 1'b1;
          end else if (q.qt == 2'h2) begin
            nxt.sda_oe = 1'b0;
            nxt.sda_o = 1'b1;
            nxt.cs = ASEL_LEVEL;
          end else begin
            nxt.st = H_IDLE;
          end
        end
      endcase
    end
    // Busy kept as a flop so the output never shows a state decode glitch
    nxt.busy = (nxt.st != H_IDLE);
  end

  // Single state register
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      q <= HOST_RST;
    end else if (ce_in) begin
      q <= nxt;
    end
  end

  assign rdata_out = q.rdata;
  assign busy_out = q.busy;
  assign link.control_clock = q.scl;
  assign link.address_select_pin = q.cs;
  assign link.sda_host_out = q.sda_o;
  assign link.sda_host_oe = q.sda_oe;
endmodule : dmcp_host

// ==== bench/dmcp_link_properties.sv ====
`timescale 1ns/1ps
module dmcp_link_properties (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ctl_rst_n_in,
  // Link wires
  input wire logic control_clock,
  input wire logic address_select_pin,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic control_data_in
);
  logic clk_q_ff;
  logic dat_q_ff;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic rise;
  logic spi_seen_ff;
  // Rises since the last start; saturates so later bytes stay out of reach
  assign rise = control_clock & ~clk_q_ff;
  always_comb begin
    nxt_bit_cnt = bit_cnt_ff;
    if (clk_q_ff & control_clock & dat_q_ff & ~control_data_in & address_select_pin) begin
      nxt_bit_cnt = 4'h0;
    end else if (rise && bit_cnt_ff != 4'hF) begin
      nxt_bit_cnt = bit_cnt_ff + 4'h1;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      clk_q_ff <= 1'b1;
      dat_q_ff <= 1'b1;
      bit_cnt_ff <= 4'hF;
    end else begin
      clk_q_ff <= control_clock;
      dat_q_ff <= control_data_in;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end
  // Select seen low since reset: the device has gone write-only
  always_ff @(posedge mclk_in) begin
    if (srst_in || !ctl_rst_n_in) begin
      spi_seen_ff <= 1'b0;
    end else if (!address_select_pin) begin
      spi_seen_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  // Open drain: the device may only pull low
  dev_pin_low_a: assert property (sda_dev_oe |-> sda_dev_out == 1'b0 && !control_data_in)
    else $error("device pull did not bring the line low");
  // No data output once serial-peripheral mode is in
  spi_no_drive_a: assert property (spi_seen_ff |-> !sda_dev_oe)
    else $error("device drives data after serial-peripheral mode");
  spi_quiet_a: assert property (!address_select_pin |-> !sda_dev_oe)
    else $error("device drives data inside a select frame");
  // Device data moves only while the clock is low
  dev_edge_a: assert property ($changed(sda_dev_oe) |-> !control_clock)
    else $error("device data changed with clock high");
  clk_low_a: assert property ($fell(control_clock) |-> !control_clock [*8] ##[1:8] control_clock)
    else $error("link clock low phase wrong length");
  clk_high_a: assert property ($rose(control_clock) |-> control_clock [*8])
    else $error("link clock high phase too short");
  frame_open_a: assert property ($fell(address_select_pin) |-> control_clock)
    else $error("select fell with clock low");
  frame_close_a: assert property ($rose(address_select_pin) |-> control_clock)
    else $error("select rose with clock low");
  addr_quiet_a: assert property (rise && bit_cnt_ff < 4'h8 |-> !sda_dev_oe)
    else $error("device drove during the address byte");
  addr_ack_a: assert property (rise && bit_cnt_ff == 4'h8 |-> !control_data_in && !sda_host_oe)
    else $error("address byte not acknowledged by the device");
endmodule : dmcp_link_properties

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  import dmcp_pkg::*;
  typedef struct packed {
    logic [1:0] op;
    logic [7:0] ptr;
    logic [7:0] wd;
  } dmcp_row_t;
  localparam int NROW = 14;
  localparam int LIMIT = 20000;
  // Command, pointer byte, data byte; expectations come from the model
  localparam dmcp_row_t ROWS [NROW] = '{
    '{OP_I2C_RD, 8'h00, 8'h00}, '{OP_I2C_PTR, 8'h01, 8'h00}, '{OP_I2C_RD, 8'h00, 8'h00},
    '{OP_I2C_WR, 8'h01, 8'h5A}, '{OP_I2C_RD, 8'h00, 8'h00}, '{OP_I2C_WR, 8'h84, 8'h3C},
    '{OP_I2C_WR, 8'h85, 8'h77}, '{OP_I2C_PTR, 8'h81, 8'h00}, '{OP_I2C_RD, 8'h00, 8'h00},
    '{OP_I2C_PTR, 8'h7E, 8'h00}, '{OP_I2C_RD, 8'h00, 8'h00},
    '{OP_SPI_WR, 8'h82, 8'hA5}, '{OP_SPI_WR, 8'h03, 8'h11}, '{OP_SPI_WR, 8'h80, 8'h22}
  };
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ctl_rst_n_in = 1'b1;
  logic ce_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic busy_out;
  logic [NREG*8-1:0] regs_out;
  logic [IDX_W-1:0] ptr_idx_out;
  logic ptr_auto_out;
  logic spi_mode_out;
  logic [7:0] m_reg [NREG];
  logic [IDX_W-1:0] m_idx;
  logic m_auto;
  logic m_spi;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  dmcp_link_if link ();
  dmcp_host u_dmcp_host (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .busy_out(busy_out), .link(link));
  dmcp_dev u_dmcp_dev (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in),
    .ctl_rst_n_in(ctl_rst_n_in), .link(link), .regs_out(regs_out),
    .ptr_idx_out(ptr_idx_out), .ptr_auto_out(ptr_auto_out), .spi_mode_out(spi_mode_out));
  dmcp_link_properties u_props (.mclk_in(mclk_in), .srst_in(srst_in),
    .ctl_rst_n_in(ctl_rst_n_in),
    .control_clock(link.control_clock), .address_select_pin(link.address_select_pin),
    .sda_host_oe(link.sda_host_oe), .sda_dev_out(link.sda_dev_out),
    .sda_dev_oe(link.sda_dev_oe), .control_data_in(link.control_data_in));
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  // Hang guard, well above the fifteen transfers of the run
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_reg(input logic [NREG*8-1:0] got, input logic [NREG*8-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_st(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_st
  // One-cycle strobes with a gap cycle, so no signal is set twice at one edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(posedge mclk_in);
    d = rdata_out;
  endtask : rd
  task automatic run_op(input dmcp_row_t r);
    int n;
    n = 0;
    wr(HA_PTR, r.ptr);
    wr(HA_WDATA, r.wd);
    wr(HA_CMD, {6'h00, r.op});
    @(posedge mclk_in);
    while (busy_out !== 1'b0 && n < 5000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 5000) begin
      bad_count++;
      complete_run();
    end
  endtask : run_op
  function automatic logic [NREG*8-1:0] m_pack();
    logic [NREG*8-1:0] v;
    for (int k = 0; k < NREG; k++) v[8*k +: 8] = m_reg[k];
    return v;
  endfunction : m_pack
  task automatic m_reset;
    for (int k = 0; k < NREG; k++) m_reg[k] = REG_RST[k];
    m_idx = 3'h0;
    m_auto = 1'b0;
    m_spi = 1'b0;
  endtask : m_reset
  initial begin
    logic [7:0] got;
    m_reset();
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    // Table of ordinary transfers; pointer and register model kept alongside
    for (int i = 0; i < NROW; i++) begin
      run_op(ROWS[i]);
      m_spi = m_spi | (ROWS[i].op == OP_SPI_WR);
      // Status after each transfer: idle, no missing device ack recorded
      rd(HA_STATUS, got);
      cmp_byte(got, {5'h00, ROWS[i].op == OP_SPI_WR, 2'h0});
      if (ROWS[i].op == OP_I2C_RD) begin
        rd(HA_RDATA, got);
        cmp_byte(got, (m_idx < NREG) ? m_reg[m_idx] : 8'h00);
        if (m_auto) m_idx = m_idx + 3'h1;
      end else begin
        m_idx = ROWS[i].ptr[2:0];
        m_auto = ROWS[i].ptr[AUTO_INC_BIT];
        if (ROWS[i].op != OP_I2C_PTR && m_idx < NREG) m_reg[m_idx] = ROWS[i].wd;
        if (ROWS[i].op != OP_I2C_PTR && m_auto) m_idx = m_idx + 3'h1;
      end
      cmp_reg(regs_out, m_pack());
      cmp_st({spi_mode_out, ptr_auto_out, ptr_idx_out}, {m_spi, m_auto, m_idx});
    end
    // Device reset pin after serial-peripheral use: defaults and two-wire again
    ctl_rst_n_in <= 1'b0;
    @(posedge mclk_in);
    ctl_rst_n_in <= 1'b1;
    @(posedge mclk_in);
    m_reset();
    cmp_reg(regs_out, m_pack());
    cmp_st({spi_mode_out, ptr_auto_out, ptr_idx_out}, 5'h00);
    run_op('{OP_I2C_RD, 8'h00, 8'h00});
    rd(HA_RDATA, got);
    cmp_byte(got, REG_RST[0]);
    rd(3'h7, got);
    cmp_byte(got, 8'h00);
    // Clock enable low freezes the command port, so this write is lost
    wr(HA_PTR, 8'h12);
    ce_in <= 1'b0;
    wr(HA_PTR, 8'h55);
    ce_in <= 1'b1;
    rd(HA_PTR, got);
    cmp_byte(got, 8'h12);
    complete_run();
  end
endmodule : tb
